// [rtl/pms_pkg.sv]
/*
 * Shared constants for the MAC-side pin output source multiplexer.
 * Assumes registers reached over APB with 32-bit data, one word per register.
 */
// Summary of operation
// RULE1: The receive data pins 7..4 selector register exists only in the large package variant.
// RULE2: In that register bits 15:12, 11:8, 7:4, 3:0 select pins rxd7, rxd6, rxd5, rxd4; RW, reset 0.
// RULE3: Code 0000 passes the pin's normal interface signal through.
// RULE4: Code 1001 drives constant one and code 1000 drives constant zero.
// RULE5: Code 0111 routes the test pattern checker error or loss of sync indication.
// RULE6: Code 0110 routes the third indicator light signal.
// RULE7: Software must not write codes 0101 or 1010 to 1111, which are reserved.
// RULE8: Code 0100 routes energy detect, meaningful only at gigabit and 100 Mb/s.
// RULE9: Code 0011 routes wake-on-LAN and code 0010 the receive start-of-frame pulse.
// RULE10: Code 0001 routes the transmit start-of-frame pulse.
// RULE11: Large variant second register holds carrier 11:8, collision 7:4, rx error 3:0; 15:12 read 0.
// RULE12: Small variant second register holds general pin 1 in 7:4 and pin 0 in 3:0; 15:8 read 0.
// RULE13: Small variant code 0000 drives general pin 1 with collision and pin 0 with rx error.
// RULE14: A build parameter picks the variant; each pin mux follows its stored selector.
// RULE15: A reserved code drives the pin to zero.
package pms_pkg;
	localparam logic [11:0] REG1_INDEX   = 12'h171;
	localparam logic [11:0] REG2_INDEX   = 12'h172;
	localparam logic [13:0] REG1_ADDR    = {REG1_INDEX, 2'b00};
	localparam logic [13:0] REG2_ADDR    = {REG2_INDEX, 2'b00};
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam int          SEL_W        = 4;
	localparam int          NPINS        = 7;
	localparam int          NSRC         = 8;
	localparam logic [3:0]  SEL_NORMAL   = 4'h0;
	localparam logic [3:0]  SEL_TX_SFD   = 4'h1;
	localparam logic [3:0]  SEL_RX_SFD   = 4'h2;
	localparam logic [3:0]  SEL_WOL      = 4'h3;
	localparam logic [3:0]  SEL_ENERGY   = 4'h4;
	localparam logic [3:0]  SEL_LED3     = 4'h6;
	localparam logic [3:0]  SEL_PRBS     = 4'h7;
	localparam logic [3:0]  SEL_ZERO     = 4'h8;
	localparam logic [3:0]  SEL_ONE      = 4'h9;
	localparam int          SRC_TX_SFD   = 0;
	localparam int          SRC_RX_SFD   = 1;
	localparam int          SRC_WOL      = 2;
	localparam int          SRC_ENERGY   = 3;
	localparam int          SRC_LED3     = 4;
	localparam int          SRC_PRBS     = 5;
	localparam logic        VARIANT_LARGE = 1'b1;
endpackage

// [rtl/pms_sel_if.sv]
/*
 * Carrier between the register file and the pin multiplexer.
 * Assumes one clock domain; selectors are stored register values, or code 1000 for the pins the small variant lacks.
 */
`timescale 1ns/1ps
interface pms_sel_if;
	logic [pms_pkg::NPINS*pms_pkg::SEL_W-1:0] sel;
	logic [pms_pkg::NPINS-1:0]                normal;
	logic [pms_pkg::NSRC-1:0]                 src;
	logic [pms_pkg::NPINS-1:0]                pin;
	modport regs (output sel, output normal, output src, input pin);
	modport mux  (input sel, input normal, input src, output pin);
endinterface

// [rtl/pms_pin_mux.sv]
/*
 * Combinational per-pin output source selection.
 * Assumes selectors and sources on the core clock; outputs are registered by the caller.
 */
`timescale 1ns/1ps
module pms_pin_mux (
	pms_sel_if.mux sif
);
	genvar i;
	for (i = 0; i < pms_pkg::NPINS; i++) begin : g_pin
		wire [3:0] s = sif.sel[i*pms_pkg::SEL_W +: pms_pkg::SEL_W];
		assign sif.pin[i] =
			(s == pms_pkg::SEL_NORMAL) ? sif.normal[i] :                  // RULE3
			(s == pms_pkg::SEL_TX_SFD) ? sif.src[pms_pkg::SRC_TX_SFD] :   // RULE10
			(s == pms_pkg::SEL_RX_SFD) ? sif.src[pms_pkg::SRC_RX_SFD] :   // RULE9
			(s == pms_pkg::SEL_WOL)    ? sif.src[pms_pkg::SRC_WOL] :      // RULE9
			(s == pms_pkg::SEL_ENERGY) ? sif.src[pms_pkg::SRC_ENERGY] :   // RULE8
			(s == pms_pkg::SEL_LED3)   ? sif.src[pms_pkg::SRC_LED3] :     // RULE6
			(s == pms_pkg::SEL_PRBS)   ? sif.src[pms_pkg::SRC_PRBS] :     // RULE5
			(s == pms_pkg::SEL_ONE)    ? 1'b1 :                           // RULE4
			1'b0;                                                         // RULE15
	end
endmodule

// [rtl/pms_top.sv]
/*
 * APB register file and registered MAC-side pin outputs of the source multiplexer.
 * Assumes an APB master on pclk; indication inputs come from other clock
 * domains or pins and are synchronised here.
 */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module pms_top #(
	parameter logic VARIANT = pms_pkg::VARIANT_LARGE
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:4]  rxd_normal,
	input  wire logic        carrier_normal,
	input  wire logic        collision_normal,
	input  wire logic        rx_error_normal,
	input  wire logic        tx_sfd_pulse,
	input  wire logic        rx_sfd_pulse,
	input  wire logic        wake_on_lan_indication,
	input  wire logic        energy_detect,
	input  wire logic        third_indicator_light,
	input  wire logic        prbs_error_or_lost,
	output logic      [7:4]  rxd_pin,
	output logic             carrier_pin,
	output logic             collision_pin,
	output logic             rx_error_pin
);
	pms_sel_if sif ();

	logic [15:0] reg1_q;
	logic [15:0] reg2_q;
	logic [12:0] sync1_q;
	logic [12:0] sync2_q;
	logic [6:0]  pin_q;

	// Bits from outside pclk: 12:9 rxd7..4, 8 carrier, 7 collision, 6 rx error, 5:0 sources
	wire  [12:0] async_in = {rxd_normal, carrier_normal, collision_normal, rx_error_normal,
		prbs_error_or_lost, third_indicator_light, energy_detect,
		wake_on_lan_indication, rx_sfd_pulse, tx_sfd_pulse};

	wire         setup     = psel & ~penable;
	wire         access    = psel & penable;
	wire         hit1      = (paddr == {2'b00, pms_pkg::REG1_ADDR}) & VARIANT;    // RULE1
	wire         hit2      = (paddr == {2'b00, pms_pkg::REG2_ADDR});
	wire         bad_addr  = ~hit1 & ~hit2;
	// Writes land in the access cycle, where pready is always high
	wire         wr1       = access & pwrite & hit1;
	wire         wr2       = access & pwrite & hit2;
	wire  [15:0] wmask2    = VARIANT ? 16'h0FFF : 16'h00FF;                      // RULE11 RULE12
	wire  [15:0] rd_word   = hit1 ? reg1_q : (hit2 ? (reg2_q & wmask2) : 16'h0000);

	// Pin order: 0..3 = rxd4..7, 4 = carrier, 5 = collision, 6 = rx error
	wire  [3:0]  sel_carrier = VARIANT ? reg2_q[11:8] : pms_pkg::SEL_ZERO;
	wire  [3:0]  sel_col     = reg2_q[7:4];                                     // RULE11 RULE12
	wire  [3:0]  sel_rxer    = reg2_q[3:0];                                     // RULE11 RULE12
	wire  [15:0] sel_rxd     = VARIANT ? reg1_q : {4{pms_pkg::SEL_ZERO}};        // RULE2 RULE1

	assign sif.sel    = {sel_rxer, sel_col, sel_carrier, sel_rxd};               // RULE14
	assign sif.normal = {sync2_q[6], sync2_q[7], sync2_q[8], sync2_q[12:9]};        // RULE3 RULE13
	assign sif.src    = {2'b00, sync2_q[5:0]};
	pms_pin_mux u_mux (
		.sif (sif)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg1_q <= pms_pkg::REG_RESET;                                  // RULE2
			reg2_q <= pms_pkg::REG_RESET;
		end else begin
			if (wr1) begin
				reg1_q <= pwdata[15:0];                                    // RULE2
			end
			if (wr2) begin
				reg2_q <= pwdata[15:0] & wmask2;                           // RULE11 RULE12
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 13'h0000;
			sync2_q <= 13'h0000;
			pin_q   <= 7'h00;
		end else begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
			pin_q   <= sif.pin;                                            // RULE13
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & bad_addr;
			prdata  <= (setup & ~pwrite) ? {16'h0000, rd_word} : 32'h00000000;
		end
	end

	assign rxd_pin       = pin_q[3:0];
	assign carrier_pin   = pin_q[4];
	assign collision_pin = pin_q[5];
	assign rx_error_pin  = pin_q[6];
endmodule

// [dv/pms_checker.sv]
/* Port assertions for the pin source mux. Assumes the large variant; bound below. */
`timescale 1ns/1ps
module pms_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:4]  rxd_pin
);
	logic [3:0] sel4_q;
	wire        setup = psel && !penable, mapped = paddr == 16'h05C4 || paddr == 16'h05C8;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) sel4_q <= 4'h0;
		else if (psel && penable && pwrite && paddr == 16'h05C4) sel4_q <= pwdata[3:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_a: assert property (setup |=> pready) else $error("no ready");
	ready_once_a: assert property (pready |=> !pready) else $error("long ready");
	ready_cause_a: assert property (pready |-> $past(setup)) else $error("stray ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	unmapped_err_a: assert property (setup && !mapped |=> pslverr) else $error("no error");
	mapped_ok_a: assert property (setup && mapped |=> !pslverr) else $error("bad error");
	pin_one_a: assert property (sel4_q == 4'h9 && $stable(sel4_q) |-> rxd_pin[4])
		else $error("pin not one");
	pin_zero_a: assert property ((sel4_q == 4'h8 || sel4_q == 4'h5 || sel4_q > 4'h9)
		&& $stable(sel4_q) |-> !rxd_pin[4]) else $error("pin not zero");
endmodule
bind pms_top pms_checker pms_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .rxd_pin);

// [dv/pms_mac_model.sv]
/* MAC side model sampling the pins. Assumes pins settle before each rising edge. */
`timescale 1ns/1ps
module pms_mac_model (
	input wire logic       pclk,
	input wire logic [6:0] pins,
	output logic     [6:0] seen
);
	always_ff @(posedge pclk) seen <= pins;
endmodule

// [dv/mac_pin_output_source_mux_test.sv]
/* Bench: code table loop, then an unmapped read. Assumes the large variant. */
`timescale 1ns/1ps
module mac_pin_output_source_mux_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic err;
	logic [6:0] src = 7'h00, pins, seen, pat [4] = '{7'h55, 7'h33, 7'h0F, 7'h2A};
	logic [0:15][7:0] rows = 128'h06102132435764758798A7B7C7D7E7F7;
	wire [8:0] ext = {2'b10, src};
	int fail_count = 0, num_checks = 0;
	always #20 pclk = ~pclk;
	pms_top pms_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rxd_normal({4{src[6]}}), .carrier_normal(src[6]), .collision_normal(src[6]),
		.rx_error_normal(src[6]), .tx_sfd_pulse(src[0]), .rx_sfd_pulse(src[1]), .energy_detect(src[3]),
		.wake_on_lan_indication(src[2]), .third_indicator_light(src[4]), .prbs_error_or_lost(src[5]),
		.rxd_pin(pins[6:3]), .carrier_pin(pins[2]), .collision_pin(pins[1]), .rx_error_pin(pins[0]));
	pms_mac_model pms_mac_model_i (.pclk, .pins, .seen);
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) $display("ERROR %0t got %h want %h", $time, got, exp);
		fail_count += int'(got !== exp);
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n = 0;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk) n++; while (pready !== 1'b1 && n < 16);
		check(32'(n < 16), 32'h1);
		if (n == 16) tally_and_finish;
		rd = prdata;
		err = pslverr;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int r = 0; r < 16; r++) begin
			apb(1'b0, 16'h05C8, 32'h0);
			check(rd, {20'h0, {3{(r == 0) ? 4'h0 : rows[r - 1][7:4]}}});
			check(32'(err), 32'h0);
			apb(1'b0, 16'h05C4, 32'h0);
			check(rd, {16'h0, {4{(r == 0) ? 4'h0 : rows[r - 1][7:4]}}});
			apb(1'b1, 16'h05C4, {16'hFFFF, {4{rows[r][7:4]}}});
			apb(1'b1, 16'h05C8, {16'hFFFF, {4{rows[r][7:4]}}});
			{psel, penable} <= 2'b00;
			foreach (pat[t]) begin
				src <= pat[t];
				repeat (5) @(posedge pclk);
				check(32'(seen), 32'({7{ext[rows[r][3:0]]}}));
			end
		end
		apb(1'b0, 16'h05CC, 32'h0);
		check(rd, 32'h0);
		check(32'(err), 32'h1);
		// Mid-run reset clears selectors and pins
		{psel, penable} <= 2'b00;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check(32'(pins), 32'h0);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 16'h05C4, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 16'h05C8, 32'h0);
		check(rd, 32'h0);
		{psel, penable} <= 2'b00;
		tally_and_finish;
	end
endmodule
